// File: hbi_host_cpu.sv
// bus master model that drives the host pins of the port
`timescale 1ns/1ps

module hbi_host_cpu (
    input wire logic clk,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe_n,
    output hbi_pkg::hbi_pins_in_t pins
);
    import hbi_pkg::*;
    logic [7:0] last_q = 8'h_00;
    initial begin
        pins = '1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // st is {rd_n, wr_n, cs_n, iack_n, dack_n}; data released shows inverse of last
    // data byte driven on the bus
    task automatic cyc(input logic [5:0] s, input logic [7:0] d, input logic [4:0] st,
                       input int n, output logic [7:0] q, output logic oe);
        logic [7:0] dv;
        q = 8'h_00;
        oe = 1'b1;
        @(negedge clk);
        dv = st[3] ? ~last_q : d;
        last_q = dv;
        pins = {s, dv, st};
        repeat (n) begin
            @(posedge clk);
            #1;
            if (host_data_oe_n === 1'b0) begin
                q = host_data_out;
                oe = 1'b0;
            end
        end
        // strobes rise first while select and data still stand
        @(negedge clk);
        pins = {s, dv, 2'b11, st[2], 2'b11};
        @(negedge clk);
        pins = {s, ~last_q, 5'b1_1111};
        last_q = ~last_q;
        repeat (4) @(negedge clk);
    endtask : cyc
endmodule : hbi_host_cpu

// File: hbi_host_port.sv
// host-side parallel bus port: register access, wait, interrupt and acknowledge
`timescale 1ns/1ps

// Behaviour
// - the six select lines choose the register read or written on each access.
// - eight-bit data bus carries all bytes, bit 0 least significant, bit 7 most.
// - with select and read strobe low, the selected register is driven onto the bus.
// - the read strobe is ignored while select is high, except in single-address DMA acknowledge cycles.
// - with select low, bus data is written when the write strobe rises; the code drops the write if wait is still active at the rise.
// - the write strobe is ignored unless select is low.
// - with select high the bus floats, except acknowledge and single-address DMA cycles.
// - bus is also enabled in interrupt and single-address DMA acknowledge cycles.
// - wait output only active in read/write cycles under a wait mode.
// - wait asserts at strobe start on empty receive or full transmit queue.
// - interrupt request asserts whenever an enabled interrupting condition exists.
// - acknowledge answer is float, vector, call instruction or zero, as configured.
// - vector is fixed or altered by current interrupt status, as configured.
// - with no interrupt pending, acknowledge is ignored and bus floats.
// - the crystal clock drives the rate generator and internal clocking.
// - master reset low clears state asynchronously, without a clock edge.
module hbi_host_port #(
    parameter int CLK_DIV = hbi_pkg::INT_CLK_DIV,
    parameter logic [7:0] CALL_OPCODE = hbi_pkg::CALL_OPCODE_RST
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic master_reset_n,
    input wire hbi_pkg::hbi_pins_in_t pins_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    output logic transfer_wait_out,
    output logic transfer_wait_oe_n,
    output logic interrupt_request_out,
    output logic interrupt_request_oe_n,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr_pulse,
    output logic reg_rd_pulse,
    input wire logic [7:0] reg_rdata,
    input wire hbi_pkg::hbi_wait_t wait_mode,
    input wire logic rx_empty,
    input wire logic tx_full,
    input wire logic irq_pending,
    input wire hbi_pkg::hbi_iack_t iack_mode,
    input wire logic vector_by_status,
    input wire logic [7:0] vector_base,
    input wire logic [2:0] irq_status,
    output logic sys_tick
);
    import hbi_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_IACK} hbi_state_t;

    hbi_pins_in_t pins_s;
    logic [$bits(hbi_pins_in_t)-1:0] sync_out;
    hbi_state_t state_q, state_d;
    logic wait_q, wait_d;
    logic drive_q, drive_d;
    logic [7:0] dout_q, dout_d;
    logic irq_q, irq_d;
    logic wr_q, wr_d;
    logic rd_q, rd_d;
    logic [5:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d;
    logic [$clog2(CLK_DIV+1)-1:0] div_q, div_d;
    logic tick_q, tick_d;
    logic od_low_q;
    logic rd_act, wr_act, iack_act, dma_rd;

    ////////////////////////////////////////////////////////////////////////////////
    // input synchroniser
    hbi_sync #(
        .WIDTH($bits(hbi_pins_in_t)),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .master_reset_n(master_reset_n),
        .din(pins_in),
        .dout(sync_out)
    );
    assign pins_s = hbi_pins_in_t'(sync_out);

    function automatic logic wait_needed(input hbi_wait_t m, input logic is_rd,
                                         input logic empty, input logic full);
        logic rx_on;
        logic tx_on;
        rx_on = (m == WAIT_RX) || (m == WAIT_EITHER);
        tx_on = (m == WAIT_TX) || (m == WAIT_EITHER);
        return is_rd ? (rx_on && empty) : (tx_on && full);
    endfunction : wait_needed

    function automatic logic [7:0] iack_byte(input hbi_iack_t m, input logic by_stat,
                                             input logic [7:0] base, input logic [2:0] st,
                                             input logic [7:0] call_op);
        logic [7:0] v;
        v = by_stat ? {base[7:VEC_STATUS_BITS], st} : base;
        unique case (m)
            IACK_VECTOR: return v;
            IACK_CALL: return call_op;
            IACK_ZERO, IACK_FLOAT: return ZERO_BYTE;
        endcase
    endfunction : iack_byte

    ////////////////////////////////////////////////////////////////////////////////
    // access sequencer, wait only inside accesses
    always_comb begin
        rd_act = !pins_s.cs_n && !pins_s.rd_n;
        wr_act = !pins_s.cs_n && !pins_s.wr_n;
        // acknowledge only counts with an interrupt pending
        iack_act = !pins_s.iack_n && irq_pending;
        dma_rd = !pins_s.dack_n && !pins_s.rd_n;
        state_d = state_q;
        wait_d = 1'b0;
        wr_d = 1'b0;
        rd_d = 1'b0;
        addr_d = addr_q;
        wdata_d = wdata_q;
        dout_d = dout_q;
        unique case (state_q)
            ST_IDLE: begin
                if (iack_act) begin
                    state_d = ST_IACK;
                end else if (rd_act) begin
                    state_d = ST_READ;
                    addr_d = pins_s.sel;
                    wait_d = wait_needed(wait_mode, 1'b1, rx_empty, tx_full);
                    rd_d = !wait_d;
                end else if (wr_act) begin
                    state_d = ST_WRITE;
                    addr_d = pins_s.sel;
                    wdata_d = pins_s.data;
                    wait_d = wait_needed(wait_mode, 1'b0, rx_empty, tx_full);
                end
            end
            ST_READ: begin
                if (rd_act) begin
                    wait_d = wait_q && wait_needed(wait_mode, 1'b1, rx_empty, tx_full);
                    rd_d = wait_q && !wait_d;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (wr_act) begin
                    wdata_d = pins_s.data;
                    wait_d = wait_q && wait_needed(wait_mode, 1'b0, rx_empty, tx_full);
                end else begin
                    wr_d = !pins_s.cs_n && !wait_q;
                    state_d = ST_IDLE;
                end
            end
            ST_IACK: begin
                if (pins_s.iack_n) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
        drive_d = (state_d == ST_READ) || dma_rd
                  || (state_d == ST_IACK && iack_mode != IACK_FLOAT);
        if (state_d == ST_IACK) begin
            dout_d = iack_byte(iack_mode, vector_by_status, vector_base, irq_status,
                               CALL_OPCODE);
        end else if (drive_d) begin
            dout_d = reg_rdata;
        end
        irq_d = irq_pending;
        tick_d = (div_q == $bits(div_q)'(CLK_DIV - 1));
        div_d = tick_d ? '0 : $bits(div_q)'(div_q + 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // asynchronous master reset
    always_ff @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            state_q <= ST_IDLE;
            wait_q <= 1'b0;
            drive_q <= 1'b0;
            dout_q <= '0;
            irq_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            div_q <= '0;
            tick_q <= 1'b0;
            od_low_q <= 1'b0;
        end else if (rst) begin
            state_q <= ST_IDLE;
            wait_q <= 1'b0;
            drive_q <= 1'b0;
            dout_q <= '0;
            irq_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            div_q <= '0;
            tick_q <= 1'b0;
            od_low_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            drive_q <= drive_d;
            dout_q <= dout_d;
            irq_q <= irq_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            div_q <= div_d;
            tick_q <= tick_d;
            od_low_q <= 1'b0;
        end
    end

    assign host_data_out = dout_q;
    assign host_data_oe_n = !drive_q;
    assign transfer_wait_out = od_low_q;
    assign transfer_wait_oe_n = !wait_q;
    assign interrupt_request_out = od_low_q;
    assign interrupt_request_oe_n = !irq_q;
    assign reg_addr = addr_q;
    assign reg_wdata = wdata_q;
    assign reg_wr_pulse = wr_q;
    assign reg_rd_pulse = rd_q;
    assign sys_tick = tick_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !master_reset_n);

    AST_SEL_LATCH: assert property (
        (state_q == ST_IDLE && state_d == ST_READ) |=> reg_addr == $past(pins_s.sel)
    ) else $error("select code not latched");
    AST_READ_DRIVE: assert property (
        state_q == ST_READ |-> !host_data_oe_n
    ) else $error("read cycle not driving bus");
    AST_FLOAT_UNSELECTED: assert property (
        (pins_s.cs_n && pins_s.iack_n && pins_s.dack_n) |=> host_data_oe_n
    ) else $error("bus driven while unselected");
    AST_WRITE_ON_RISE: assert property (
        reg_wr_pulse |-> $past(state_q == ST_WRITE) && $past(!pins_s.cs_n)
    ) else $error("write without strobe rise");
    AST_WRITE_IGNORED: assert property (
        (state_q == ST_IDLE && pins_s.cs_n) |=> !reg_wr_pulse
    ) else $error("write taken while unselected");
    AST_DMA_DRIVE: assert property (
        (!pins_s.dack_n && !pins_s.rd_n) |=> !host_data_oe_n
    ) else $error("dma acknowledge not driving bus");
    AST_WAIT_IDLE: assert property (
        state_q == ST_IDLE |-> transfer_wait_oe_n
    ) else $error("wait active outside access");
    AST_WAIT_RX: assert property (
        (state_q == ST_IDLE && state_d == ST_READ && rx_empty
         && (wait_mode == WAIT_RX || wait_mode == WAIT_EITHER))
        |=> !transfer_wait_oe_n ##0 !reg_rd_pulse
    ) else $error("wait missing on empty receive queue");
    AST_IRQ: assert property (
        irq_pending |=> !interrupt_request_oe_n
    ) else $error("interrupt request not raised");
    AST_VECTOR: assert property (
        (state_d == ST_IACK && iack_mode == IACK_VECTOR && !vector_by_status)
        |=> host_data_out == $past(vector_base)
    ) else $error("fixed vector wrong");
    AST_IACK_IGNORED: assert property (
        (state_q == ST_IDLE && !irq_pending) |=> state_q != ST_IACK
    ) else $error("acknowledge taken with nothing pending");
    AST_TICK: assert property (
        sys_tick |=> !sys_tick
    ) else $error("divider tick too long");

    COV_READ: cover property (state_q == ST_READ ##1 state_q == ST_IDLE);
    COV_WRITE: cover property (reg_wr_pulse);
    COV_IACK: cover property (state_q == ST_IACK && !host_data_oe_n);
    COV_WAIT: cover property (!transfer_wait_oe_n ##1 transfer_wait_oe_n);

endmodule : hbi_host_port

// File: hbi_pkg.sv
// shared types and constants for the host bus interface
package hbi_pkg;

    localparam int SYNC_STAGES = 2;
    localparam int INT_CLK_DIV = 2;
    localparam logic [7:0] CALL_OPCODE_RST = 8'h_CD;
    localparam logic [7:0] ZERO_BYTE = 8'h_00;
    localparam int VEC_STATUS_BITS = 3;

    typedef enum logic [1:0] {
        WAIT_NONE,
        WAIT_RX,
        WAIT_TX,
        WAIT_EITHER
    } hbi_wait_t;

    typedef enum logic [1:0] {
        IACK_FLOAT,
        IACK_VECTOR,
        IACK_CALL,
        IACK_ZERO
    } hbi_iack_t;

    typedef struct packed {
        logic [5:0] sel;
        logic [7:0] data;
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic iack_n;
        logic dack_n;
    } hbi_pins_in_t;

endpackage : hbi_pkg

// File: hbi_sync.sv
// multi-bit two-flop input synchroniser
`timescale 1ns/1ps

module hbi_sync #(
    parameter int WIDTH = 8,
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic master_reset_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage_q [STAGES];

    ////////////////////////////////////////////////////////////////////////////////
    // flop chain, first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            always_ff @(posedge clk or negedge master_reset_n) begin
                if (!master_reset_n) begin
                    stage_q[g] <= '1;
                end else if (rst) begin
                    stage_q[g] <= '1;
                end else begin
                    stage_q[g] <= (g == 0) ? din : stage_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    assign dout = stage_q[STAGES-1];

endmodule : hbi_sync

// File: host_bus_interface_test.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps

module host_bus_interface_test;
    import hbi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic master_reset_n = 1'b1;
    hbi_pins_in_t pins;
    logic [7:0] host_data_out, reg_wdata, q, d, e;
    logic host_data_oe_n, transfer_wait_out, transfer_wait_oe_n, oe;
    logic interrupt_request_out, interrupt_request_oe_n, reg_wr_pulse, reg_rd_pulse, sys_tick;
    logic [5:0] reg_addr, s;
    logic [7:0] reg_rdata = 8'h_00;
    logic [7:0] vector_base = 8'h_00;
    logic [2:0] irq_status = 3'h_0;
    hbi_wait_t wait_mode = WAIT_NONE;
    hbi_iack_t iack_mode = IACK_FLOAT;
    logic rx_empty = 1'b0, tx_full = 1'b0, irq_pending = 1'b0, vector_by_status = 1'b0;
    logic [7:0] regs [64];
    int exm [64];
    logic [13:0] wq [$];
    logic [13:0] w;
    int err_total = 0, samples_checked = 0, rdc = 0, wlow = 0, tk, i, m, r0;

    initial begin
        forever #25 clk = ~clk;
    end

    hbi_host_port hbi_host_port_inst (
        .clk(clk), .rst(rst), .master_reset_n(master_reset_n), .pins_in(pins),
        .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
        .transfer_wait_out(transfer_wait_out), .transfer_wait_oe_n(transfer_wait_oe_n),
        .interrupt_request_out(interrupt_request_out),
        .interrupt_request_oe_n(interrupt_request_oe_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr_pulse(reg_wr_pulse), .reg_rd_pulse(reg_rd_pulse),
        .reg_rdata(reg_rdata), .wait_mode(wait_mode), .rx_empty(rx_empty), .tx_full(tx_full),
        .irq_pending(irq_pending), .iack_mode(iack_mode), .vector_by_status(vector_by_status),
        .vector_base(vector_base), .irq_status(irq_status), .sys_tick(sys_tick)
    );

    hbi_host_cpu hbi_host_cpu_inst (
        .clk(clk), .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
        .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register side and monitors
    always @(posedge clk) begin
        if (reg_wr_pulse === 1'b1) begin
            regs[reg_addr] <= reg_wdata;
            wq.push_back({reg_addr, reg_wdata});
        end
        if (reg_rd_pulse === 1'b1) rdc <= rdc + 1;
        if (transfer_wait_oe_n === 1'b0) wlow <= wlow + 1;
    end
    always @(negedge clk) begin
        reg_rdata <= regs[reg_addr];
    end

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] v);
        samples_checked++;
        if (v !== ex) begin
            $display("mismatch %s expected %h seen %h", nm, ex, v);
            err_total++;
        end
    endtask : chk

    task automatic complete_run;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic bus(input logic [5:0] a, input logic [7:0] v, input logic [4:0] st);
        hbi_host_cpu_inst.cyc(a, v, st, 7, q, oe);
    endtask : bus

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (i = 0; i < 64; i++) begin
            regs[i] = 8'h_00;
            exm[i] = 0;
        end
        r0 = $urandom(90);
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        for (i = 0; i < 6; i++) begin
            s = (i == 0) ? 6'h_00 : (i == 1) ? 6'h_3f : 6'($urandom);
            d = 8'($urandom);
            bus(s, d, 5'b1_0011);
            exm[s] = d;
            chk("wr_count", 8'h_01, 8'(wq.size()));
            if (wq.size() > 0) begin
                w = wq.pop_front();
                chk("wr_addr", {2'b00, s}, {2'b00, w[13:8]});
                chk("wr_data", d, w[7:0]);
            end
        end
        bus(6'h_00, 8'h_5a, 5'b1_0111);
        wait_mode = WAIT_TX;
        tx_full = 1'b1;
        bus(6'h_00, 8'h_a5, 5'b1_0011);
        chk("wr_refused", 8'h_00, 8'(wq.size()));
        chk("wait_tx", 8'h_01, 8'(wlow != 0));
        tk = wlow;
        tx_full = 1'b0;
        wait_mode = WAIT_RX;
        for (i = 0; i < 4; i++) begin
            s = (i == 0) ? 6'h_00 : (i == 1) ? 6'h_3f : 6'($urandom);
            bus(s, 8'h_00, 5'b0_1011);
            chk("rd_oe", 8'h_00, {7'h_00, oe});
            chk("rd_data", 8'(exm[s]), q);
        end
        chk("rd_pulses", 8'h_04, 8'(rdc));
        m = rdc;
        bus(6'h_00, 8'h_00, 5'b0_1111);
        chk("rd_ign_oe", 8'h_01, {7'h_00, oe});
        chk("rd_ign_pulse", 8'(m), 8'(rdc));
        chk("wait_idle", 8'(tk), 8'(wlow));
        rx_empty = 1'b1;
        s = 6'h_3f;
        fork
            hbi_host_cpu_inst.cyc(s, 8'h_00, 5'b0_1011, 14, q, oe);
            begin
                repeat (6) @(negedge clk);
                chk("wait_on", 8'h_00, {7'h_00, transfer_wait_oe_n});
                chk("wait_level", 8'h_00, {7'h_00, transfer_wait_out});
                chk("wait_no_pop", 8'(m), 8'(rdc));
                rx_empty = 1'b0;
            end
        join
        chk("wait_rd_data", 8'(exm[s]), q);
        chk("wait_pop", 8'(m + 1), 8'(rdc));
        wait_mode = WAIT_NONE;
        irq_pending = 1'b1;
        vector_base = 8'($urandom);
        irq_status = 3'($urandom);
        repeat (2) @(negedge clk);
        chk("irq_on", 8'h_00, {7'h_00, interrupt_request_oe_n});
        chk("irq_level", 8'h_00, {7'h_00, interrupt_request_out});
        for (m = 0; m < 8; m++) begin
            iack_mode = hbi_iack_t'(m[1:0]);
            vector_by_status = m[2];
            e = m[2] ? {vector_base[7:3], irq_status} : vector_base;
            e = (m[1:0] == 2) ? CALL_OPCODE_RST : (m[1:0] == 3) ? ZERO_BYTE : e;
            bus(6'h_00, 8'h_00, 5'b1_1101);
            chk("iack_oe", 8'(m[1:0] == 0), {7'h_00, oe});
            if (m[1:0] != 0) chk("iack_data", e, q);
        end
        // single-address dma reads the register selected last
        m = rdc;
        bus(s, 8'h_00, 5'b0_1110);
        chk("dma_oe", 8'h_00, {7'h_00, oe});
        chk("dma_data", 8'(exm[s]), q);
        chk("dma_no_pop", 8'(m), 8'(rdc));
        @(negedge clk);
        #5 master_reset_n = 1'b0;
        #5 chk("async_rst", 8'h_01, {7'h_00, interrupt_request_oe_n});
        @(negedge clk);
        master_reset_n = 1'b1;
        irq_pending = 1'b0;
        repeat (3) @(negedge clk);
        chk("irq_off", 8'h_01, {7'h_00, interrupt_request_oe_n});
        iack_mode = IACK_ZERO;
        bus(6'h_00, 8'h_00, 5'b1_1101);
        chk("iack_idle", 8'h_01, {7'h_00, oe});
        tk = 0;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (sys_tick === 1'b1) tk++;
        end
        chk("ticks", 8'(20 / INT_CLK_DIV), 8'(tk));
        complete_run();
    end
endmodule : host_bus_interface_test
